// ===== hw/pin_edge_sync.v
module pin_edge_sync #(
  parameter W = 2
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [W-1:0] pin_i,
  output reg [W-1:0] rise_o
);
  reg [W-1:0] meta;
  reg [W-1:0] stable;
  reg [W-1:0] last;

  // Two-stage synchroniser, then a rising-edge pulse from the second stage
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= {W{1'b0}};
      stable <= {W{1'b0}};
      last <= {W{1'b0}};
      rise_o <= {W{1'b0}};
    end else begin
      meta <= pin_i;
      stable <= meta;
      last <= stable;
      rise_o <= stable & ~last;
    end
  end
endmodule

// ===== hw/timer0_async_ctrl.v
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`include "timer0_map.vh"
module timer0_async_ctrl (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg hreadyout_o,
  output reg [31:0] hrdata_o,
  output reg hresp_o,
  input wire global_irq_en_i,
  input wire sysclk_from_rc_i,
  input wire [1:0] irq_ack_i,
  input wire crystal_clk_i,
  input wire crystal_in_pin_i,
  output reg compare_irq_o,
  output reg overflow_irq_o,
  output reg ext_clock_buf_en_o,
  output reg crystal_osc_en_o,
  output reg prescaler_b_reset_o
);
  reg rst_meta;
  reg rst_n;

  // Reset release through two flip-flops
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Register state
  reg ext_clock_input_en;
  reg async_clock_select;
  reg counter_update_busy;
  reg compare_update_busy;
  reg ctrl_a_update_busy;
  reg ctrl_b_update_busy;
  reg [1:0] irq_mask;
  reg [1:0] irq_flags;
  reg timer_sync_hold;
  reg prescaler_a_reset;
  reg prescaler_b_reset;
  reg [7:0] counter_value;
  reg [7:0] counter_temp;
  reg [7:0] compare_value;
  reg [7:0] compare_temp;
  reg [7:0] control_reg_a;
  reg [7:0] control_a_temp;
  reg [7:0] control_reg_b;
  reg [7:0] control_b_temp;
  reg count_down;
  reg match_block;

  // Bus state
  reg wr_pend;
  reg rd_pend;
  reg [7:0] addr_q;

  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr[`ADDR_MSB:`ADDR_LSB] == offset[`ADDR_MSB:`ADDR_LSB]);
    end
  endfunction

  // Timer clock edges from the crystal and from the pin
  wire [1:0] async_edge;
  pin_edge_sync #(
    .W(2)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .pin_i({crystal_in_pin_i, crystal_clk_i}),
    .rise_o(async_edge)
  );

  // Source of the timer clock
  wire sel_edge = ext_clock_input_en ? async_edge[1] : async_edge[0];
  wire src_tick = async_clock_select ? sel_edge : 1'b1;
  wire xfer_tick = src_tick;

  wire cnt_tick;
  timer0_prescaler u_psc (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .src_tick_i(src_tick),
    .clear_i(prescaler_a_reset),
    .sel_i(control_reg_b[`CS_MSB:0]),
    .tick_o(cnt_tick)
  );

  wire [1:0] wave_mode = {control_reg_a[`MODE_HI_BIT], control_reg_a[`MODE_LO_BIT]};

  // Bus write strobes, taken in the data phase
  wire wr = wr_pend;
  wire [7:0] wd = hwdata_i[7:0];
  wire wr_status = wr && hit(addr_q, `REG_ASYNC_STATUS);
  wire wr_mask = wr && hit(addr_q, `REG_IRQ_MASK);
  wire wr_flags = wr && hit(addr_q, `REG_IRQ_FLAGS);
  wire wr_gen = wr && hit(addr_q, `REG_GEN_CTRL);
  wire wr_cnt = wr && hit(addr_q, `REG_COUNTER);
  wire wr_cmp = wr && hit(addr_q, `REG_COMPARE);
  wire wr_cta = wr && hit(addr_q, `REG_CTRL_A);
  wire wr_ctb = wr && hit(addr_q, `REG_CTRL_B);
  wire addr_ok = (addr_q[1:0] == 2'h0) && (addr_q <= `REG_CTRL_B);

  // Counter sequence for the selected waveform mode
  reg [7:0] next_count;
  reg next_down;
  reg hit_cmp;
  reg hit_ovf;
  always @* begin
    next_count = counter_value;
    next_down = count_down;
    hit_cmp = 1'b0;
    hit_ovf = 1'b0;
    if (cnt_tick) begin
      hit_cmp = (counter_value == compare_value) && !match_block;
      case (wave_mode)
        `WAVE_PHASE: begin
          if (count_down) begin
            if (counter_value == `CNT_BOTTOM) begin
              next_down = 1'b0;
              next_count = counter_value + 8'h01;
              hit_ovf = 1'b1;
            end else begin
              next_count = counter_value - 8'h01;
            end
          end else if (counter_value == `CNT_MAX) begin
            next_down = 1'b1;
            next_count = counter_value - 8'h01;
          end else begin
            next_count = counter_value + 8'h01;
          end
        end
        `WAVE_CTC: begin
          next_count = (counter_value == compare_value) ? `CNT_BOTTOM : counter_value + 8'h01;
          hit_ovf = (counter_value == `CNT_MAX);
        end
        `WAVE_NORMAL, `WAVE_FAST: begin
          next_count = counter_value + 8'h01;
          hit_ovf = (counter_value == `CNT_MAX);
        end
        default: next_count = counter_value;
      endcase
    end
  end

  // Flag clears from software ones or vector execution
  wire [1:0] flag_clr = (wr_flags ? wd[1:0] : 2'b00) | irq_ack_i;
  wire [1:0] flag_set = {hit_cmp, hit_ovf};

  // Readback multiplexer
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = `BYTE_ZERO;
    if (hit(addr_q, `REG_ASYNC_STATUS)) begin
      rd_byte[`EXT_CLK_EN_BIT] = ext_clock_input_en;
      rd_byte[`ASYNC_SEL_BIT] = async_clock_select;
      rd_byte[`CNT_BUSY_BIT] = counter_update_busy;
      rd_byte[`CMP_BUSY_BIT] = compare_update_busy;
      rd_byte[`CTLA_BUSY_BIT] = ctrl_a_update_busy;
      rd_byte[`CTLB_BUSY_BIT] = ctrl_b_update_busy;
    end else if (hit(addr_q, `REG_IRQ_MASK)) begin
      rd_byte[1:0] = irq_mask;
    end else if (hit(addr_q, `REG_IRQ_FLAGS)) begin
      rd_byte[1:0] = irq_flags;
    end else if (hit(addr_q, `REG_GEN_CTRL)) begin
      rd_byte[`SYNC_HOLD_BIT] = timer_sync_hold;
      rd_byte[`PSC_A_BIT] = prescaler_a_reset;
      rd_byte[`PSC_B_BIT] = prescaler_b_reset;
    end else if (hit(addr_q, `REG_COUNTER)) begin
      rd_byte = counter_value;
    end else if (hit(addr_q, `REG_COMPARE)) begin
      rd_byte = compare_temp;
    end else if (hit(addr_q, `REG_CTRL_A)) begin
      rd_byte = control_a_temp;
    end else if (hit(addr_q, `REG_CTRL_B)) begin
      rd_byte = control_b_temp;
    end
    if (!addr_ok) begin
      rd_byte = `BYTE_ZERO;
    end
  end

  // AHB-Lite slave: writes with no wait, reads with one wait state
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= `BYTE_ZERO;
      hreadyout_o <= 1'b1;
      hrdata_o <= `WORD_ZERO;
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      if (rd_pend) begin
        hrdata_o <= {24'h00_0000, rd_byte};
        hreadyout_o <= 1'b1;
        rd_pend <= 1'b0;
        wr_pend <= 1'b0;
      end else if (hready_i) begin
        wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
        rd_pend <= hsel_i && htrans_i[1] && !hwrite_i;
        hreadyout_o <= !(hsel_i && htrans_i[1] && !hwrite_i);
        if (hsel_i && htrans_i[1]) begin
          addr_q <= haddr_i[7:0];
        end
      end
    end
  end

  // Clock select, busy flags, holding copies and transfers
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_clock_input_en <= 1'b0;
      async_clock_select <= 1'b0;
      counter_update_busy <= 1'b0;
      compare_update_busy <= 1'b0;
      ctrl_a_update_busy <= 1'b0;
      ctrl_b_update_busy <= 1'b0;
      counter_temp <= `BYTE_ZERO;
      compare_temp <= `BYTE_ZERO;
      control_a_temp <= `BYTE_ZERO;
      control_b_temp <= `BYTE_ZERO;
      compare_value <= `BYTE_ZERO;
      control_reg_a <= `BYTE_ZERO;
      control_reg_b <= `BYTE_ZERO;
    end else begin
      if (wr_status) begin
        ext_clock_input_en <= wd[`EXT_CLK_EN_BIT];
        async_clock_select <= wd[`ASYNC_SEL_BIT] && sysclk_from_rc_i;
      end
      // Counter: holding copy, then load on a timer clock edge
      if (wr_cnt) begin
        counter_temp <= wd;
        counter_update_busy <= async_clock_select;
      end else if (counter_update_busy && xfer_tick) begin
        counter_update_busy <= 1'b0;
      end
      // Compare value
      if (wr_cmp) begin
        compare_temp <= wd;
        if (async_clock_select) begin
          compare_update_busy <= 1'b1;
        end else begin
          compare_value <= wd;
        end
      end else if (compare_update_busy && xfer_tick) begin
        compare_value <= compare_temp;
        compare_update_busy <= 1'b0;
      end
      // Control register A
      if (wr_cta) begin
        control_a_temp <= wd & `CTLA_MASK;
        if (async_clock_select) begin
          ctrl_a_update_busy <= 1'b1;
        end else begin
          control_reg_a <= wd & `CTLA_MASK;
        end
      end else if (ctrl_a_update_busy && xfer_tick) begin
        control_reg_a <= control_a_temp;
        ctrl_a_update_busy <= 1'b0;
      end
      // Control register B; the force strobe bit is not kept
      if (wr_ctb) begin
        control_b_temp <= wd & `CTLB_MASK;
        if (async_clock_select) begin
          ctrl_b_update_busy <= 1'b1;
        end else begin
          control_reg_b <= wd & `CTLB_MASK;
        end
      end else if (ctrl_b_update_busy && xfer_tick) begin
        control_reg_b <= control_b_temp;
        ctrl_b_update_busy <= 1'b0;
      end
    end
  end

  // Counter, direction and compare blocking after a counter write
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= `BYTE_ZERO;
      count_down <= 1'b0;
      match_block <= 1'b0;
    end else begin
      if (wr_cnt && !async_clock_select) begin
        counter_value <= wd;
        match_block <= 1'b1;
      end else if (counter_update_busy && xfer_tick && !wr_cnt) begin
        counter_value <= counter_temp;
        match_block <= 1'b1;
      end else begin
        counter_value <= next_count;
        count_down <= next_down;
        if (cnt_tick) begin
          match_block <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask and sticky flags; a set wins over a clear
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 2'b00;
      irq_flags <= 2'b00;
    end else begin
      if (wr_mask) begin
        irq_mask <= wd[1:0];
      end
      irq_flags <= (irq_flags & ~flag_clr) | flag_set;
    end
  end

  // Prescaler reset bits and synchronisation hold
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_sync_hold <= 1'b0;
      prescaler_a_reset <= 1'b0;
      prescaler_b_reset <= 1'b0;
    end else if (wr_gen) begin
      timer_sync_hold <= wd[`SYNC_HOLD_BIT];
      if (timer_sync_hold && !wd[`SYNC_HOLD_BIT]) begin
        prescaler_a_reset <= 1'b0;
        prescaler_b_reset <= 1'b0;
      end else begin
        prescaler_a_reset <= prescaler_a_reset | wd[`PSC_A_BIT];
        prescaler_b_reset <= prescaler_b_reset | wd[`PSC_B_BIT];
      end
    end else if (!timer_sync_hold) begin
      // Reset A clears next cycle in sync mode and waits for a timer clock edge in async; reset B always clears next cycle
      prescaler_a_reset <= prescaler_a_reset && !src_tick;
      prescaler_b_reset <= 1'b0;
    end
  end

  // Registered outputs
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      compare_irq_o <= 1'b0;
      overflow_irq_o <= 1'b0;
      ext_clock_buf_en_o <= 1'b0;
      crystal_osc_en_o <= 1'b0;
      prescaler_b_reset_o <= 1'b0;
    end else begin
      compare_irq_o <= irq_mask[`CMP_BIT] && global_irq_en_i && irq_flags[`CMP_BIT];
      overflow_irq_o <= irq_mask[`OVF_BIT] && global_irq_en_i && irq_flags[`OVF_BIT];
      ext_clock_buf_en_o <= ext_clock_input_en && async_clock_select;
      crystal_osc_en_o <= !ext_clock_input_en;
      prescaler_b_reset_o <= prescaler_b_reset;
    end
  end

  // Size is unused: every access is treated as a word
  wire unused_size = |hsize_i;
endmodule

// ===== hw/timer0_map.vh
`ifndef TIMER0_MAP_VH
`define TIMER0_MAP_VH

// Byte offsets of the registers
`define REG_ASYNC_STATUS 8'h00
`define REG_IRQ_MASK 8'h04
`define REG_IRQ_FLAGS 8'h08
`define REG_GEN_CTRL 8'h0C
`define REG_COUNTER 8'h10
`define REG_COMPARE 8'h14
`define REG_CTRL_A 8'h18
`define REG_CTRL_B 8'h1C
`define ADDR_LSB 2
`define ADDR_MSB 7

// Async status fields
`define EXT_CLK_EN_BIT 6
`define ASYNC_SEL_BIT 5
`define CNT_BUSY_BIT 4
`define CMP_BUSY_BIT 3
`define CTLA_BUSY_BIT 1
`define CTLB_BUSY_BIT 0

// Interrupt mask and flag fields
`define CMP_BIT 1
`define OVF_BIT 0

// General control fields
`define SYNC_HOLD_BIT 7
`define PSC_A_BIT 1
`define PSC_B_BIT 0

// Control register fields and masks
`define MODE_HI_BIT 3
`define MODE_LO_BIT 6
`define CTLA_MASK 8'hCB
`define CTLB_MASK 8'h07
`define CS_MSB 2

// Waveform modes
`define WAVE_NORMAL 2'h0
`define WAVE_PHASE 2'h1
`define WAVE_CTC 2'h2
`define WAVE_FAST 2'h3

// Counter limits and reset values
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h0000_0000

// Prescaler tap widths per divisor
`define PSC_WIDTH 10
`define TAP_DIV8 4'h3
`define TAP_DIV32 4'h5
`define TAP_DIV64 4'h6
`define TAP_DIV128 4'h7
`define TAP_DIV256 4'h8
`define TAP_DIV1024 4'hA

`endif

// ===== hw/timer0_prescaler.v
`include "timer0_map.vh"
module timer0_prescaler (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire src_tick_i,
  input wire clear_i,
  input wire [2:0] sel_i,
  output wire tick_o
);
  reg [`PSC_WIDTH-1:0] div;
  reg [3:0] tap;
  wire [`PSC_WIDTH-1:0] need;

  // Tap width for the selected divisor; zero width means every source tick, except select 0, which gives no ticks
  always @* begin
    case (sel_i)
      3'h2: tap = `TAP_DIV8;
      3'h3: tap = `TAP_DIV32;
      3'h4: tap = `TAP_DIV64;
      3'h5: tap = `TAP_DIV128;
      3'h6: tap = `TAP_DIV256;
      3'h7: tap = `TAP_DIV1024;
      default: tap = 4'h0;
    endcase
  end

  assign need = ~({`PSC_WIDTH{1'b1}} << tap);
  assign tick_o = src_tick_i && (sel_i != 3'h0) && ((div & need) == need);

  // Free-running divider, held at zero while its reset bit stands
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= {`PSC_WIDTH{1'b0}};
    end else if (clear_i) begin
      div <= {`PSC_WIDTH{1'b0}};
    end else if (src_tick_i) begin
      div <= div + {{(`PSC_WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ===== testbench/async_timer_sync_status_irq_test.sv
module async_timer_sync_status_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gie = 1'b0;
  logic rc = 1'b0;
  logic [1:0] ack = 2'h0;
  logic xtal = 1'b0;
  logic xtal_run = 1'b0;
  logic [1:0] irq;
  logic buf_en, osc_en, pscb, hsel, hwrite, hready, hresp, hung;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int failures = 0;
  int samples_checked = 0;
  // System clock and a slow crystal of unrelated phase
  always #12.5 clk = ~clk;
  always #263 xtal = xtal ^ xtal_run;
  core_bus_model i_core_bus_model (.sys_clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata), .hung_o(hung));
  timer0_async_ctrl i_timer0_async_ctrl (.sys_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp), .global_irq_en_i(gie), .sysclk_from_rc_i(rc),
    .irq_ack_i(ack), .crystal_clk_i(xtal & osc_en), .crystal_in_pin_i(xtal), .compare_irq_o(irq[1]),
    .overflow_irq_o(irq[0]), .ext_clock_buf_en_o(buf_en), .crystal_osc_en_o(osc_en), .prescaler_b_reset_o(pscb));
  task automatic results();
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    i_core_bus_model.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_core_bus_model.access(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask
  // Reads until the expected value shows, bounded
  task automatic poll(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h0000_0000;
    while (n < 100) begin
      i_core_bus_model.access(1'b0, a, 8'h00, q);
      if (q === {24'h00_0000, exp})
        break;
      n++;
    end
    check(q, {24'h00_0000, exp});
    if (n >= 100)
      results();
  endtask
  task automatic wait_irq(input int which);
    int n;
    n = 0;
    while (irq[which] !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check(irq[which], 1'b1);
    if (n >= 1000)
      results();
  endtask
  // A hung bus access ends the run
  always @(posedge hung) begin
    failures++;
    results();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(8'h02, 32'h0000_0000);
    check(hresp, 1'b0);
    check(osc_en, 1'b1);
    check(buf_en, 1'b0);
    $display("reset and map test done");
    wr(8'h14, 8'h05);
    rd(8'h14, 32'h0000_0005);
    wr(8'h18, 8'hFF);
    rd(8'h18, 32'h0000_00CB);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 32'h0000_0007);
    wr(8'h04, 8'hFF);
    rd(8'h04, 32'h0000_0003);
    wr(8'h0C, 8'h02);
    rd(8'h0C, 32'h0000_0000);
    wr(8'h18, 8'h00);
    gie <= 1'b1;
    wr(8'h1C, 8'h01);
    wait_irq(1);
    rd(8'h08, 32'h0000_0002);
    wr(8'h08, 8'h02);
    // Flag clears on the data phase edge, the request one edge later
    repeat (2) @(posedge clk);
    check(irq[1], 1'b0);
    wait_irq(0);
    ack <= 2'h1;
    @(posedge clk);
    ack <= 2'h0;
    repeat (2) @(posedge clk);
    check(irq[0], 1'b0);
    wr(8'h18, 8'h40);
    wr(8'h08, 8'h03);
    wait_irq(0);
    wr(8'h1C, 8'h00);
    // Counter stops five ticks after the turn at the bottom
    rd(8'h10, 32'h0000_0005);
    wr(8'h08, 8'h03);
    gie <= 1'b0;
    $display("sync timer test done");
    wr(8'h00, 8'h20);
    rd(8'h00, 32'h0000_0000);
    rc <= 1'b1;
    wr(8'h00, 8'h20);
    rd(8'h00, 32'h0000_0020);
    check(buf_en, 1'b0);
    xtal_run <= 1'b1;
    wr(8'h1C, 8'h00);
    poll(8'h00, 8'h20);
    xtal_run <= 1'b0;
    repeat (10) @(posedge clk);
    wr(8'h10, 8'h40);
    wr(8'h14, 8'h22);
    wr(8'h18, 8'h01);
    wr(8'h1C, 8'h00);
    wr(8'h0C, 8'h02);
    rd(8'h00, 32'h0000_003B);
    rd(8'h0C, 32'h0000_0002);
    rd(8'h14, 32'h0000_0022);
    xtal_run <= 1'b1;
    poll(8'h00, 8'h20);
    poll(8'h0C, 8'h00);
    rd(8'h10, 32'h0000_0040);
    $display("async transfer test done");
    wr(8'h00, 8'h40);
    wr(8'h00, 8'h60);
    repeat (2) @(posedge clk);
    check(buf_en, 1'b1);
    check(osc_en, 1'b0);
    rd(8'h00, 32'h0000_0060);
    wr(8'h00, 8'h00);
    xtal_run <= 1'b0;
    wr(8'h0C, 8'h83);
    rd(8'h0C, 32'h0000_0083);
    check(pscb, 1'b1);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 32'h0000_0000);
    check(pscb, 1'b0);
    $display("sync hold test done");
    results();
  end
endmodule

// ===== testbench/core_bus_model.sv
module core_bus_model (
  input wire logic sys_clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o,
  output logic hung_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0000_0000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0000_0000;
    hung_o = 1'b0;
  end
  // Waits for an edge with ready high, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1 && n < 40) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 40)
      hung_o <= 1'b1;
  endtask
  // One single word transfer; entered just after a rising edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    hsel_o <= 1'b1;
    haddr_o <= {24'h00_0000, a};
    hwrite_o <= wr;
    htrans_o <= 2'h2;
    wait_ready();
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= {24'h00_0000, d};
    wait_ready();
    q = hrdata_i;
  endtask
endmodule

// ===== testbench/timer0_properties.sv
module timer0_checker (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic [31:0] hrdata_o,
  input wire logic global_irq_en_i,
  input wire logic compare_irq_o,
  input wire logic overflow_irq_o,
  input wire logic ext_clock_buf_en_o,
  input wire logic crystal_osc_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Accepted bus requests
  wire logic taken = hsel_i && hready_i && htrans_i[1];
  wire logic rd_taken = taken && !hwrite_i;
  AST_READ_ONE_WAIT: assert property (rd_taken |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read did not finish after one wait cycle");
  AST_WRITE_NO_WAIT: assert property (taken && hwrite_i |=> hreadyout_o)
    else $error("write data phase was stretched");
  AST_UNMAPPED_ZERO: assert property (rd_taken && haddr_i[7:0] > 8'h1C |-> ##2 hrdata_o == 32'h0000_0000)
    else $error("unmapped read returned data");
  AST_UPPER_ZERO: assert property ($rose(hreadyout_o) |-> hrdata_o[31:8] == 24'h00_0000)
    else $error("read data above the byte not zero");
  AST_BUF_STOPS_OSC: assert property (ext_clock_buf_en_o |-> !crystal_osc_en_o)
    else $error("oscillator runs with external clock buffer on");
  AST_CMP_NEEDS_GIE: assert property (compare_irq_o |-> $past(global_irq_en_i))
    else $error("compare request without global enable");
  AST_OVF_NEEDS_GIE: assert property (overflow_irq_o |-> $past(global_irq_en_i))
    else $error("overflow request without global enable");
  AST_GIE_OFF_QUIET: assert property (!global_irq_en_i |=> !compare_irq_o && !overflow_irq_o)
    else $error("request stayed with global enable low");
endmodule

bind timer0_async_ctrl timer0_checker i_timer0_checker (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .global_irq_en_i(global_irq_en_i),
  .compare_irq_o(compare_irq_o), .overflow_irq_o(overflow_irq_o),
  .ext_clock_buf_en_o(ext_clock_buf_en_o), .crystal_osc_en_o(crystal_osc_en_o));
